// ---- bench/sps_spi_master.sv ----
// behavioural external spi master driving the slave pins, mode 0, msb first
`timescale 1ns/100ps
module sps_spi_master (
    input  wire logic miso,     // data from the slave, pulled high when released
    output logic      sck,      // serial clock, low between frames
    output logic      mosi,     // data to the slave
    output logic      selectN   // slave select, active low
);
    initial begin
        sck     = 1'b0;
        mosi    = 1'b1;
        selectN = 1'b1;
    end

    // select moves only between bits; generous settle for the synchroniser
    task automatic sel(input logic lvl);
        selectN = lvl;
        #100;
    endtask : sel

    // each phase 32 ns, well over two core cycles
    task automatic xfer(input logic [7:0] tx, input int bits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < bits; i++) begin
            mosi = tx[7-i];
            #32;
            rx   = {rx[6:0], miso};
            sck  = 1'b1;
            #32;
            sck  = 1'b0;
        end
        // released line must not keep the last bit
        mosi = ~mosi;
        #40;
    endtask : xfer
endmodule : sps_spi_master

// ---- bench/tb_top.sv ----
// self-checking bench for the spi select and slave buffering core
`timescale 1ns/100ps
module tb_top;
    import sps_pkg::*;
    typedef struct packed { logic [7:0] tx; logic [7:0] mosi; } sps_row_t;

    logic                clock         = 1'b0;
    logic                sys_rst       = 1'b1;
    logic                clkEn         = 1'b1;
    logic [2:0]          avs_address   = 3'h0;
    logic                avs_read      = 1'b0;
    logic                avs_write     = 1'b0;
    logic [BUS_W-1:0]    avs_writedata = 32'h0000_0000;
    logic [BUS_W-1:0]    avs_readdata;
    logic                avs_waitrequest;
    sps_pin_in_t         pinIn;
    sps_pin_out_t        pinOut;
    logic                sck;
    logic                mosi;
    logic                selectN;
    logic                misoLine;
    logic [7:0]          rx;
    logic [31:0]         junk;
    int                  fails         = 0;
    int                  checksDone    = 0;
    sps_row_t            rows [3]      = '{'{8'hA5, 8'h3C}, '{8'h00, 8'hFF}, '{8'hFF, 8'h5A}};

    always #2.5 clock = ~clock;

    assign pinIn    = {sck, mosi, selectN};
    // pull-up on the data-out line while released
    assign misoLine = pinOut.misoOeN ? 1'b1 : pinOut.miso;

    sps_core dut (
        .clock           (clock),
        .sys_rst         (sys_rst),
        .clkEn           (clkEn),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .pinIn           (pinIn),
        .pinOut          (pinOut)
    );

    sps_spi_master master (
        .miso    (misoLine),
        .sck     (sck),
        .mosi    (mosi),
        .selectN (selectN)
    );

    task automatic end_sim;
        if (fails == 0 && checksDone > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one avalon transfer; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 40) begin
            fails++;
            end_sim();
        end
    endtask : bus

    task automatic wreg(input logic [2:0] a, input logic [31:0] d);
        bus(1'b1, a, d, junk);
    endtask : wreg

    task automatic rchk(input string what, input logic [2:0] a, input logic [31:0] exp, input logic [31:0] mask);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(what, exp & mask, q & mask);
    endtask : rchk

    initial begin
        #200000;
        fails++;
        end_sim();
    end

    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        rchk("ctrl reset", ADDR_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
        rchk("flags reset", ADDR_FLAGS, 32'h0000_0004, 32'hFFFF_FFFF);
        rchk("unmapped", 3'h5, 32'h0000_0000, 32'hFFFF_FFFF);
        wreg(3'h6, 32'hFFFF_FFFF);
        wreg(ADDR_CTRL, 32'hFFFF_FF41);
        rchk("ctrl upper bits", ADDR_CTRL, 32'h0000_0041, 32'hFFFF_FFFF);
        foreach (rows[i]) begin
            wreg(ADDR_DATA, {24'hFF_FFFF, rows[i].tx});
            chk("oe idle", 32'h1, {31'h0, pinOut.misoOeN});
            master.sel(1'b0);
            chk("oe selected", 32'h0, {31'h0, pinOut.misoOeN});
            master.xfer(rows[i].mosi, 8, rx);
            master.sel(1'b1);
            chk("sent byte", {24'h0, rows[i].tx}, {24'h0, rx});
            rchk("done flag", ADDR_FLAGS, 32'h0000_0001, 32'h0000_0001);
            rchk("rx byte", ADDR_DATA, {24'h0, rows[i].mosi}, 32'h0000_00FF);
            wreg(ADDR_FLAGS, 32'h0000_001B);
        end
        // buffered, no wait: dummy is the last shifted-in byte
        wreg(ADDR_CTRL, 32'h0000_0049);
        wreg(ADDR_DATA, 32'h0000_0043);
        rchk("buf full", ADDR_FLAGS, 32'h0000_0000, 32'h0000_0004);
        wreg(ADDR_DATA, 32'h0000_0045);
        master.sel(1'b0);
        master.xfer(8'h81, 8, rx);
        chk("dummy", 32'h5A, {24'h0, rx});
        rchk("after dummy", ADDR_FLAGS, 32'h0000_000C, 32'h0000_001C);
        rchk("rx buffered", ADDR_DATA, 32'h0000_0081, 32'h0000_00FF);
        wreg(ADDR_FLAGS, 32'h0000_001B);
        master.xfer(8'h7E, 8, rx);
        master.sel(1'b1);
        chk("first user", 32'h43, {24'h0, rx});
        rchk("all sent", ADDR_FLAGS, 32'h0000_001C, 32'h0000_001C);
        // buffered, wait for receive: primed while deselected
        wreg(ADDR_CTRL, 32'h0000_0059);
        wreg(ADDR_DATA, 32'h0000_0046);
        wreg(ADDR_DATA, 32'h0000_0047);
        master.sel(1'b0);
        master.xfer(8'h11, 8, rx);
        chk("no dummy", 32'h46, {24'h0, rx});
        master.xfer(8'h22, 8, rx);
        master.sel(1'b1);
        chk("second user", 32'h47, {24'h0, rx});
        // normal mode: write in mid-transfer is dropped
        wreg(ADDR_CTRL, 32'h0000_0041);
        wreg(ADDR_FLAGS, 32'h0000_001B);
        wreg(ADDR_DATA, 32'h0000_0033);
        master.sel(1'b0);
        fork
            master.xfer(8'h0F, 8, rx);
            begin
                repeat (40) @(posedge clock);
                wreg(ADDR_DATA, 32'h0000_0055);
            end
        join
        master.sel(1'b1);
        chk("collided tx", 32'h33, {24'h0, rx});
        rchk("collision", ADDR_FLAGS, 32'h0000_0002, 32'h0000_0002);
        // select rise in mid-byte abandons it
        wreg(ADDR_FLAGS, 32'h0000_001B);
        master.sel(1'b0);
        master.xfer(8'hC3, 4, rx);
        master.sel(1'b1);
        rchk("no done", ADDR_FLAGS, 32'h0000_0000, 32'h0000_0001);
        master.sel(1'b0);
        master.xfer(8'h96, 8, rx);
        master.sel(1'b1);
        rchk("resynced", ADDR_DATA, 32'h0000_0096, 32'h0000_00FF);
        // clock enable low: a whole frame passes unseen
        wreg(ADDR_FLAGS, 32'h0000_001B);
        @(posedge clock);
        clkEn <= 1'b0;
        master.sel(1'b0);
        chk("oe frozen", 32'h1, {31'h0, pinOut.misoOeN});
        master.xfer(8'hE7, 8, rx);
        master.sel(1'b1);
        chk("frozen line", 32'hFF, {24'h0, rx});
        @(posedge clock);
        clkEn <= 1'b1;
        rchk("frozen no done", ADDR_FLAGS, 32'h0000_0000, 32'h0000_0001);
        rchk("frozen rx", ADDR_DATA, 32'h0000_0096, 32'h0000_00FF);
        // select arbitration in master mode
        wreg(ADDR_FLAGS, 32'h0000_001B);
        wreg(ADDR_CTRL, 32'h0000_0007);
        master.sel(1'b0);
        rchk("ignore select", ADDR_CTRL, 32'h0000_0007, 32'h0000_007F);
        master.sel(1'b1);
        wreg(ADDR_CTRL, 32'h0000_0023);
        master.sel(1'b0);
        rchk("select output", ADDR_CTRL, 32'h0000_0023, 32'h0000_007F);
        master.sel(1'b1);
        wreg(ADDR_CTRL, 32'h0000_0003);
        master.sel(1'b0);
        rchk("forced slave", ADDR_CTRL, 32'h0000_0001, 32'h0000_007F);
        rchk("forced done", ADDR_FLAGS, 32'h0000_0001, 32'h0000_0001);
        master.sel(1'b1);
        rchk("no restore", ADDR_CTRL, 32'h0000_0001, 32'h0000_007F);
        // second reset in mid-run
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rchk("ctrl rereset", ADDR_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
        rchk("flags rereset", ADDR_FLAGS, 32'h0000_0004, 32'hFFFF_FFFF);
        end_sim();
    end
endmodule : tb_top

// ---- logic/sps_core.sv ----
// spi slave-select arbitration and slave normal/buffered shifting with avalon registers
//
// Notes on behaviour
// - master with select checked as input: low select drops master, becomes slave
// - that forced drop sets the transfer-done flag
// - select ignore set: select pin has no effect in master mode
// - select pin configured as output: master mode kept whatever its level
// - slave normal mode idles while select high; data may be loaded then
// - selected slave shifts from first clock, flags done after eight bits
// - normal mode write during a transfer is dropped and collision flagged
// - select rising halts shifting and drops the partial byte
// - buffer enable adds buffer and flags; wait-for-receive picks sub-mode
// - wait-for-receive zero: one dummy byte precedes user data
// - dummy byte is the shift register content at first transfer
// - wait-for-receive zero: writes go to buffer, moved after transfer
// - write while buffer full is lost, buffer unchanged
// - buffer-empty drops on write, rises when buffer copied after transfer
// - receive-complete set one cycle after buffer-empty rises
// - transfer-complete one cycle after receive-complete, only when all sent
// - wait-for-receive one: user data from first transfer, no dummy
// - wait-for-receive one, select high: write reaches shifter one cycle after the buffer
// - select rising resets slave state and bit counter
// - data-out driven only while selected, else released
`timescale 1ns/100ps
module sps_core (
    input  wire logic                       clock,             // core clock, 200 MHz
    input  wire logic                       sys_rst,           // synchronous reset, high
    input  wire logic                       clkEn,             // freezes all state when low
    input  wire logic [2:0]                 avs_address,       // word index
    input  wire logic                       avs_read,          // read request
    input  wire logic                       avs_write,         // write request
    input  wire logic [sps_pkg::BUS_W-1:0]  avs_writedata,     // write data
    output logic      [sps_pkg::BUS_W-1:0]  avs_readdata,      // read data
    output logic                            avs_waitrequest,   // stall
    input  wire sps_pkg::sps_pin_in_t       pinIn,             // sck, mosi, select (async)
    output sps_pkg::sps_pin_out_t           pinOut             // miso and its enable (low = drive)
);
    import sps_pkg::*;

    // synchroniser stages
    sps_pin_in_t             inMeta;
    sps_pin_in_t             inSync;
    logic                    sckLast;
    logic                    selLast;

    sps_ctrl_t               ctrl,       next_ctrl;
    sps_flags_t              flags,      next_flags;
    sps_state_t              state,      next_state;
    logic [DATA_W-1:0]       shiftReg,   next_shiftReg;
    logic [DATA_W-1:0]       txBuf,      next_txBuf;
    logic [DATA_W-1:0]       rxData,     next_rxData;
    logic [DATA_W-1:0]       rxHold,     next_rxHold;
    logic [2:0]              bitCnt,     next_bitCnt;
    logic                    primed,     next_primed;
    logic                    doneD1,     next_doneD1;
    logic                    doneD2,     next_doneD2;
    logic                    sentAllD1,  next_sentAllD1;
    logic                    sentAllD2,  next_sentAllD2;
    sps_pin_out_t            next_pinOut;
    logic [BUS_W-1:0]        next_readdata;
    logic                    next_waitrequest;

    logic                    slaveOn;
    logic                    selected;
    logic                    sckRise;
    logic                    selRise;
    logic                    accepted;
    logic                    wrCtrl;
    logic                    wrFlags;
    logic                    wrData;
    logic                    byteDone;
    logic [DATA_W-1:0]       byteIn;

    // two-flop synchroniser; first stage read only by the second
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            inMeta  <= '{sck: 1'b0, mosi: 1'b0, selectN: 1'b1};
            inSync  <= '{sck: 1'b0, mosi: 1'b0, selectN: 1'b1};
            sckLast <= 1'b0;
            selLast <= 1'b1;
        end else if (clkEn) begin
            inMeta  <= pinIn;
            inSync  <= inMeta;
            sckLast <= inSync.sck;
            selLast <= inSync.selectN;
        end
    end

    always_comb begin
        slaveOn  = ctrl.enable && !ctrl.master;
        selected = slaveOn && !inSync.selectN;
        sckRise  = inSync.sck && !sckLast;
        selRise  = inSync.selectN && !selLast;
        accepted = avs_write && !avs_waitrequest;
        wrCtrl   = accepted && (avs_address == ADDR_CTRL);
        wrFlags  = accepted && (avs_address == ADDR_FLAGS);
        wrData   = accepted && (avs_address == ADDR_DATA);
        byteIn   = {shiftReg[DATA_W-2:0], inSync.mosi};
        byteDone = (state == SL_SELECTED) && selected && sckRise && (bitCnt == LAST_BIT);
    end

    // avalon slave: one wait cycle, then the answer stands for one cycle
    always_comb begin
        next_waitrequest = 1'b1;
        next_readdata    = avs_readdata;
        if ((avs_read || avs_write) && avs_waitrequest) begin
            next_waitrequest = 1'b0;
        end
        if (avs_read && avs_waitrequest) begin
            unique case (avs_address)
                ADDR_CTRL:  next_readdata = {{(BUS_W-7){1'b0}}, ctrl};
                ADDR_FLAGS: next_readdata = {{(BUS_W-5){1'b0}}, flags};
                ADDR_DATA:  next_readdata = {{(BUS_W-DATA_W){1'b0}}, rxData};
                default:    next_readdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end else if (clkEn) begin
            avs_waitrequest <= next_waitrequest;
            avs_readdata    <= next_readdata;
        end
    end

    // core next-state logic
    always_comb begin
        next_ctrl      = ctrl;
        next_flags     = flags;
        next_state     = state;
        next_shiftReg  = shiftReg;
        next_txBuf     = txBuf;
        next_rxData    = rxData;
        next_rxHold    = rxHold;
        next_bitCnt    = bitCnt;
        next_primed    = primed;
        next_doneD1    = 1'b0;
        next_doneD2    = doneD1;
        next_sentAllD1 = 1'b0;
        next_sentAllD2 = sentAllD1;

        if (wrCtrl) begin
            next_ctrl = avs_writedata[6:0];
        end
        // clears applied first so a same-cycle set wins
        if (wrFlags) begin
            next_flags = flags & ~(avs_writedata[4:0] & FLAGS_W1C);
        end

        // ignore setting masks the pin; output pin never counts
        // master is only set again by a control write
        if (ctrl.enable && ctrl.master && !ctrl.selectPinIgnore
                && !ctrl.selectIsOutput && !inSync.selectN) begin
            next_ctrl.master = 1'b0;
            next_flags.transferDoneFlag = 1'b1;
        end

        // deselect halts shifting and resets the counter
        if (!selected || selRise) begin
            next_state  = SL_IDLE;
            next_bitCnt = '0;
        end else begin
            next_state = SL_SELECTED;
        end

        // shift on each rising sample clock edge once selected
        if (state == SL_SELECTED && selected && sckRise) begin
            next_shiftReg = byteIn;
            next_bitCnt   = bitCnt + 3'h1;
        end

        if (!ctrl.bufferModeEnable) begin
            if (byteDone) begin
                // byte complete: done flag and received byte together
                next_flags.transferDoneFlag = 1'b1;
                next_rxData                 = byteIn;
            end
            if (wrData) begin
                if (selected && (bitCnt != 3'h0)) begin
                    next_flags.writeCollisionFlag = 1'b1;
                end else begin
                    next_shiftReg = avs_writedata[DATA_W-1:0];
                end
            end
        end else begin
            if (byteDone) begin
                next_rxHold    = byteIn;
                next_doneD1    = 1'b1;
                // nothing waiting means all data has gone
                next_sentAllD1 = flags.txBufferEmptyFlag;
                if (!flags.txBufferEmptyFlag) begin
                    // buffered byte moves after the transfer
                    next_shiftReg                = txBuf;
                    next_flags.txBufferEmptyFlag = 1'b1;
                end
            end
            // wait-for-receive primes the shifter while deselected
            if (ctrl.waitForReceiveSelect && !primed && inSync.selectN
                    && !flags.txBufferEmptyFlag) begin
                next_shiftReg                = txBuf;
                next_flags.txBufferEmptyFlag = 1'b1;
                next_primed                  = 1'b1;
            end
            if (wrData) begin
                // full buffer keeps its byte, the new one is lost
                if (flags.txBufferEmptyFlag) begin
                    // writes land in the buffer only while it is empty
                    next_txBuf                   = avs_writedata[DATA_W-1:0];
                    next_flags.txBufferEmptyFlag = 1'b0;
                end
            end
            // with wait-for-receive low the shifter is never primed
            // so the first frame sends whatever it holds
            if (doneD1) begin
                // receive-complete follows buffer-empty by one cycle
                next_flags.receiveCompleteFlag = 1'b1;
                next_rxData                    = rxHold;
            end
            if (doneD2 && sentAllD2) begin
                next_flags.transferCompleteFlag = 1'b1;
            end
        end
        // a new frame needs priming again
        if (selRise || !ctrl.waitForReceiveSelect || !ctrl.bufferModeEnable) begin
            next_primed = 1'b0;
        end

        next_pinOut.misoOeN = !(slaveOn && ctrl.misoIsOutput && !inSync.selectN);
        next_pinOut.miso    = next_shiftReg[DATA_W-1];
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl      <= CTRL_RESET;
            flags     <= FLAGS_RESET;
            state     <= SL_IDLE;
            shiftReg  <= '0;
            txBuf     <= '0;
            rxData    <= '0;
            rxHold    <= '0;
            bitCnt    <= '0;
            primed    <= 1'b0;
            doneD1    <= 1'b0;
            doneD2    <= 1'b0;
            sentAllD1 <= 1'b0;
            sentAllD2 <= 1'b0;
            pinOut    <= '{miso: 1'b0, misoOeN: 1'b1};
        end else if (clkEn) begin
            ctrl      <= next_ctrl;
            flags     <= next_flags;
            state     <= next_state;
            shiftReg  <= next_shiftReg;
            txBuf     <= next_txBuf;
            rxData    <= next_rxData;
            rxHold    <= next_rxHold;
            bitCnt    <= next_bitCnt;
            primed    <= next_primed;
            doneD1    <= next_doneD1;
            doneD2    <= next_doneD2;
            sentAllD1 <= next_sentAllD1;
            sentAllD2 <= next_sentAllD2;
            pinOut    <= next_pinOut;
        end
    end

    // checks, valid while the clock enable stays high
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    sequence s_buf_done;
        byteDone && ctrl.bufferModeEnable && clkEn;
    endsequence

    sequence s_hold_en2;
        clkEn ##1 clkEn;
    endsequence

    a_master_drop: assert property (
        ctrl.enable && ctrl.master && !ctrl.selectPinIgnore && !ctrl.selectIsOutput
            && !inSync.selectN && clkEn |=> !ctrl.master && flags.transferDoneFlag)
        else $error("master not dropped on low select");

    a_ignore_keeps: assert property (
        ctrl.enable && ctrl.master && ctrl.selectPinIgnore && !wrCtrl && clkEn |=> ctrl.master)
        else $error("master lost with select ignored");

    a_output_keeps: assert property (
        ctrl.enable && ctrl.master && ctrl.selectIsOutput && !wrCtrl && clkEn |=> ctrl.master)
        else $error("master lost with select as output");

    a_idle_count: assert property (
        (!selected || selRise) && clkEn |=> bitCnt == 3'h0 && state == SL_IDLE)
        else $error("counter not reset when deselected");

    a_byte_done: assert property (
        byteDone && !ctrl.bufferModeEnable && clkEn
            |=> flags.transferDoneFlag && rxData == $past(byteIn))
        else $error("normal byte not completed");

    a_collision_flag: assert property (
        wrData && !ctrl.bufferModeEnable && selected && bitCnt != 3'h0 && clkEn
            |=> flags.writeCollisionFlag)
        else $error("collision not flagged");

    a_full_keeps: assert property (
        wrData && ctrl.bufferModeEnable && !flags.txBufferEmptyFlag && clkEn |=> $stable(txBuf))
        else $error("full buffer overwritten");

    a_empty_rises: assert property (
        s_buf_done and (!flags.txBufferEmptyFlag && !wrData) |=> flags.txBufferEmptyFlag)
        else $error("buffer empty did not rise");

    a_rxc_after: assert property (
        s_buf_done ##1 s_hold_en2 |-> flags.receiveCompleteFlag)
        else $error("receive complete late or missing");

    a_txc_after: assert property (
        (s_buf_done and flags.txBufferEmptyFlag) ##1 clkEn ##1 s_hold_en2
            |-> flags.transferCompleteFlag)
        else $error("transfer complete late or missing");

    a_miso_release: assert property (
        (inSync.selectN || !slaveOn) && clkEn |=> pinOut.misoOeN)
        else $error("data-out driven while deselected");

    a_prime_next: assert property (
        wrData && ctrl.bufferModeEnable && ctrl.waitForReceiveSelect && !primed
            && flags.txBufferEmptyFlag && inSync.selectN && clkEn ##1 (clkEn && inSync.selectN)
            |=> shiftReg == $past(txBuf))
        else $error("first write not primed into shifter");

    // data-path guards; a dropped or frozen write must leave the shifter untouched
    a_idle_shift: assert property (
        !ctrl.bufferModeEnable && !selected && !wrData && clkEn |=> $stable(shiftReg))
        else $error("shifter moved while deselected");

    a_collision_drop: assert property (
        wrData && !ctrl.bufferModeEnable && selected && bitCnt != 3'h0 && !sckRise && clkEn
            |=> $stable(shiftReg))
        else $error("colliding write reached shifter");

    a_empty_drops: assert property (
        wrData && ctrl.bufferModeEnable && flags.txBufferEmptyFlag && clkEn
            |=> !flags.txBufferEmptyFlag)
        else $error("buffer empty stayed high after write");

    a_rx_buffered: assert property (
        s_buf_done ##1 s_hold_en2 |-> rxData == $past(byteIn, 2))
        else $error("buffered byte not latched");

    a_no_prime: assert property (
        !ctrl.waitForReceiveSelect && clkEn |=> !primed)
        else $error("shifter primed with wait-for-receive low");

    // clock enable low must hold control, flags, shifter, synchroniser and pin
    a_freeze_hold: assert property (
        !clkEn |=> $stable(ctrl) && $stable(flags) && $stable(shiftReg)
            && $stable(pinOut) && $stable(inSync))
        else $error("state moved while frozen");

endmodule : sps_core

// ---- logic/sps_pkg.sv ----
// constants and carrier types for the spi select and slave buffering block
package sps_pkg;

    // register word indices on the avalon slave
    localparam logic [2:0] ADDR_CTRL  = 3'h0;
    localparam logic [2:0] ADDR_FLAGS = 3'h1;
    localparam logic [2:0] ADDR_DATA  = 3'h2;

    localparam int         DATA_W     = 8;
    localparam int         BUS_W      = 32;
    localparam logic [2:0] LAST_BIT   = 3'h7;

    // control bits as stored in the control register, bit 6 first
    typedef struct packed {
        logic misoIsOutput;          // bit 6: data-out pin direction
        logic selectIsOutput;        // bit 5: select pin direction
        logic waitForReceiveSelect;  // bit 4
        logic bufferModeEnable;      // bit 3
        logic selectPinIgnore;       // bit 2
        logic master;                // bit 1
        logic enable;                // bit 0
    } sps_ctrl_t;

    // status flags, bit 4 first
    typedef struct packed {
        logic transferCompleteFlag;  // bit 4
        logic receiveCompleteFlag;   // bit 3
        logic txBufferEmptyFlag;     // bit 2, status only
        logic writeCollisionFlag;    // bit 1
        logic transferDoneFlag;      // bit 0
    } sps_flags_t;

    localparam logic [6:0] CTRL_RESET  = 7'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h04;
    localparam logic [4:0] FLAGS_W1C   = 5'h1b;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic selectN;
    } sps_pin_in_t;

    typedef struct packed {
        logic miso;
        logic misoOeN;
    } sps_pin_out_t;

    typedef enum logic {
        SL_IDLE     = 1'b0,
        SL_SELECTED = 1'b1
    } sps_state_t;

endpackage : sps_pkg
